// file: src/adcc_conv_ctrl.sv
// Converter control: registers, start logic, successive approximation, interrupt
`timescale 1ns/1ps
module adcc_conv_ctrl #(
	parameter logic [3:0] SAMPLE_TICKS = 4'h2 // Acquisition length in ticks
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [adcc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [adcc_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [adcc_pkg::DATA_W-1:0] rdata_o,
	input wire logic special_trigger_i,
	input wire logic sleep_i,
	input wire logic rc_clk_i,
	input wire logic comparator_i,
	output logic [2:0] channel_sel_o,
	output logic [adcc_pkg::NUM_CH-1:0] analog_enable_o,
	output logic ref_high_pin_o,
	output logic ref_low_pin_o,
	output logic converter_on_o,
	output logic sample_o,
	output logic [adcc_pkg::RES_W-1:0] dac_code_o,
	output logic irq_o
);
	import adcc_pkg::*;

	adcc_regs_type r; // Registered state
	adcc_regs_type n; // Next state
	logic wr_pri; // Primary control write
	logic wr_sec; // Secondary control write
	logic start_sw; // Software start request
	logic start_trig; // Compare trigger start
	logic [IRQ_W-1:0] ev; // Events this cycle
	logic [IRQ_W-1:0] clr; // Status bits cleared by software
	logic [3:0] tick_seen; // Trials counted for checking

	// Clock generator link
	adcc_tick_if tk();

	assign tk.clk_sel = r.pri[PRI_CLK_LSB +: 2];
	assign tk.range_sel = r.sec[SEC_RANGE];
	assign tk.run = (r.state != ST_IDLE);
	assign tk.sleep = sleep_i;

	// Conversion clock enable source
	adcc_tick_gen u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.rc_clk_i(rc_clk_i),
		.tk(tk)
	);

	// Outputs straight from state flops
	assign rdata_o = r.rdata;
	assign channel_sel_o = r.pri[PRI_CH_LSB +: 3];
	assign analog_enable_o = r.sec[NUM_CH-1:0];
	assign ref_high_pin_o = r.sec[SEC_REF_HIGH];
	assign ref_low_pin_o = r.sec[SEC_REF_LOW];
	assign converter_on_o = r.pri[PRI_ON];
	assign sample_o = r.sample;
	assign dac_code_o = r.code;
	assign irq_o = r.irq;

	// Write decode
	assign wr_pri = wr_i && (addr_i == ADDR_CTRL_PRI);
	assign wr_sec = wr_i && (addr_i == ADDR_CTRL_SEC);
	// Start needs power in the value written
	assign start_sw = wr_pri && wdata_i[PRI_GO] && wdata_i[PRI_ON];
	// Trigger counts only while powered and not rewritten
	assign start_trig = special_trigger_i && r.pri[PRI_ON] && !wr_pri;

	// Next state of the whole block
	always_comb begin
		logic [RES_W-1:0] code_v;
		code_v = r.code;
		n = r;
		ev = '0;
		clr = '0;
		// Comparator crosses in from the analog side
		n.cmp_meta = comparator_i;
		n.cmp_sync = r.cmp_meta;

		// Control register writes
		if (wr_pri) begin
			// Bit 1 never stores
			n.pri = wdata_i & PRI_WMASK;
			// Go holds only together with power
			n.pri[PRI_GO] = wdata_i[PRI_GO] && wdata_i[PRI_ON];
			// A busy converter keeps its status bit set when go and power are written
			if (r.state != ST_IDLE && wdata_i[PRI_GO] && wdata_i[PRI_ON]) begin
				n.pri[PRI_GO] = 1'b1;
			end
		end
		if (wr_sec) begin
			n.sec = wdata_i;
		end
		if (wr_i && addr_i == ADDR_IRQ_MASK) begin
			n.irq_mask = wdata_i[IRQ_W-1:0];
		end
		if (wr_i && addr_i == ADDR_IRQ_STAT) begin
			clr = wdata_i[IRQ_W-1:0];
		end

		// Conversion sequence
		unique case (r.state)
			ST_IDLE: begin
				if (start_sw) begin
					// Software start
					n.state = ST_SAMPLE;
					n.samp_cnt = '0;
					n.sample = 1'b1;
				end else if (start_trig) begin
					// Compare trigger start
					n.pri[PRI_GO] = 1'b1;
					n.state = ST_SAMPLE;
					n.samp_cnt = '0;
					n.sample = 1'b1;
					ev[IRQ_TRIG] = 1'b1;
				end
			end
			ST_SAMPLE: begin
				// Hold the input for the acquisition ticks
				if (tk.tick) begin
					if (r.samp_cnt == SAMPLE_TICKS - 4'h1) begin
						n.sample = 1'b0;
						n.code = '0;
						n.code[TRIAL_FIRST] = 1'b1;
						n.bit_idx = TRIAL_FIRST;
						n.samp_cnt = '0;
						n.state = ST_CONV;
					end else begin
						n.samp_cnt = r.samp_cnt + 4'h1;
					end
				end
			end
			ST_CONV: begin
				// Count cycles since the code changed; the synchroniser lags two
				if (r.samp_cnt < CMP_SETTLE) begin
					n.samp_cnt = r.samp_cnt + 4'h1;
				end
				// One trial bit decided per settled tick
				if (tk.tick && r.samp_cnt >= CMP_SETTLE) begin
					n.samp_cnt = '0;
					if (!r.cmp_sync) begin
						code_v[r.bit_idx] = 1'b0;
					end
					if (r.bit_idx == 4'h0) begin
						// Result lands first
						n.result = code_v;
						n.state = ST_STORE;
					end else begin
						code_v[r.bit_idx - 4'h1] = 1'b1;
						n.bit_idx = r.bit_idx - 4'h1;
					end
					n.code = code_v;
				end
			end
			ST_STORE: begin
				// Status drops one cycle after the result
				n.pri[PRI_GO] = 1'b0;
				n.state = ST_IDLE;
				ev[IRQ_DONE] = 1'b1;
			end
		endcase

		// Power off or go cleared aborts
		if (r.state != ST_IDLE && r.state != ST_STORE &&
			(!n.pri[PRI_ON] || !n.pri[PRI_GO])) begin
			n.pri[PRI_GO] = 1'b0;
			n.state = ST_IDLE;
			n.sample = 1'b0;
		end

		// Sticky status, set beats clear
		n.irq_stat = (r.irq_stat & ~clr) | ev;
		n.irq = |(n.irq_stat & n.irq_mask);

		// Read data stand for one cycle only
		n.rdata = '0;
		if (rd_i) begin
			unique case (addr_i)
				ADDR_RES_HIGH: n.rdata = r.result[RES_W-1 -: DATA_W];
				ADDR_RES_LOW: n.rdata = {r.result[RES_W-DATA_W-1:0],
					{(2*DATA_W-RES_W){1'b0}}};
				ADDR_CTRL_PRI: n.rdata = r.pri & PRI_WMASK;
				ADDR_CTRL_SEC: n.rdata = r.sec;
				ADDR_IRQ_STAT: n.rdata = {{(DATA_W-IRQ_W){1'b0}}, r.irq_stat};
				ADDR_IRQ_MASK: n.rdata = {{(DATA_W-IRQ_W){1'b0}}, r.irq_mask};
				default: n.rdata = '0; // Unmapped reads zero
			endcase
		end
	end

	// State register, cleared by reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= REGS_RESET;
		end else begin
			r <= n;
		end
	end

	// Trial counter watched by the checks
	always_ff @(posedge clk_i) begin
		if (rst_i || r.state != ST_CONV) begin
			tick_seen <= '0;
		end else if (tk.tick && r.samp_cnt >= CMP_SETTLE) begin
			tick_seen <= tick_seen + 4'h1;
		end
	end

	// Steps of the finish
	sequence s_store;
		r.state == ST_STORE && r.pri[PRI_GO];
	endsequence
	sequence s_clear;
		r.state == ST_IDLE && !r.pri[PRI_GO];
	endsequence

	chk_store_then_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		s_store |=> s_clear)
		else $error("status not cleared after store");

	chk_ten_trials: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state == ST_STORE |-> tick_seen == 4'hA)
		else $error("conversion did not take ten trials");

	chk_go_while_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		r.pri[PRI_GO] == (r.state != ST_IDLE))
		else $error("status bit disagrees with converter");

	chk_sw_start: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_sw && r.state == ST_IDLE) |=> r.pri[PRI_GO] && r.state == ST_SAMPLE)
		else $error("software start not taken");

	chk_trig_start: assert property (@(posedge clk_i) disable iff (rst_i)
		(special_trigger_i && r.pri[PRI_ON] && !wr_i && r.state == ST_IDLE)
		|=> r.state == ST_SAMPLE ##1 r.irq_stat[IRQ_TRIG])
		else $error("compare trigger did not start");

	chk_off_stays_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		!converter_on_o |-> r.state == ST_IDLE && !sample_o)
		else $error("converter active while off");

	chk_unimpl_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_i && addr_i == ADDR_CTRL_PRI) |=> !rdata_o[1] && rdata_o[PRI_ON] == r.pri[PRI_ON])
		else $error("primary read shows unimplemented bit");

	chk_reset_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> r.pri == PRI_RESET && !irq_o)
		else $error("primary control not zero after reset");

	chk_done_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		s_store |=> r.irq_stat[IRQ_DONE] ##1 (irq_o == r.irq_mask[IRQ_DONE] || r.irq_stat[IRQ_TRIG]))
		else $error("completion flag missing");
endmodule

// file: inc/adcc_pkg.sv
// Register map, field layout and state types of the converter control block
package adcc_pkg;
	localparam int ADDR_W = 8; // Register address width
	localparam int DATA_W = 8; // Register data width
	localparam int RES_W = 10; // Result width
	localparam int NUM_CH = 5; // Analog input count
	localparam int IRQ_W = 2; // Interrupt event count
	// Register addresses
	localparam logic [ADDR_W-1:0] ADDR_RES_HIGH = 8'h1E;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_PRI = 8'h1F;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h21;
	localparam logic [ADDR_W-1:0] ADDR_RES_LOW = 8'h9E;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_SEC = 8'h9F;
	// Primary control fields
	localparam int PRI_CLK_LSB = 6; // Clock select, two bits
	localparam int PRI_CH_LSB = 3; // Channel select, three bits
	localparam int PRI_GO = 2; // Conversion status
	localparam int PRI_ON = 0; // Converter power
	// Secondary control fields; bits 4:0 set pins analog
	localparam int SEC_REF_HIGH = 5; // Upper reference from pin
	localparam int SEC_RANGE = 6; // Clock range select
	localparam int SEC_REF_LOW = 7; // Lower reference from pin
	// Interrupt status bits
	localparam int IRQ_DONE = 0; // Conversion complete
	localparam int IRQ_TRIG = 1; // Start by compare trigger
	// Reset values and writable bits
	localparam logic [DATA_W-1:0] PRI_RESET = 8'h00;
	localparam logic [DATA_W-1:0] PRI_WMASK = 8'hFD;
	localparam logic [DATA_W-1:0] SEC_RESET = 8'h00;
	// Clock select codes and divider terminal counts
	localparam logic [1:0] CLK_SEL_DIV_A = 2'h0;
	localparam logic [1:0] CLK_SEL_DIV_B = 2'h1;
	localparam logic [1:0] CLK_SEL_DIV_C = 2'h2;
	localparam logic [1:0] CLK_SEL_RC = 2'h3;
	localparam logic [5:0] DIV_LAST_2 = 6'h01;
	localparam logic [5:0] DIV_LAST_4 = 6'h03;
	localparam logic [5:0] DIV_LAST_8 = 6'h07;
	localparam logic [5:0] DIV_LAST_16 = 6'h0F;
	localparam logic [5:0] DIV_LAST_32 = 6'h1F;
	localparam logic [5:0] DIV_LAST_64 = 6'h3F;
	localparam logic [3:0] TRIAL_FIRST = 4'h9; // Most significant trial bit
	localparam logic [3:0] CMP_SETTLE = 4'h2; // Cycles before the synced comparator is fresh
	// Converter sequence, Gray along the path
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONV = 2'b11,
		ST_STORE = 2'b10
	} adcc_state_type;
	// Whole state of the control module
	typedef struct packed {
		adcc_state_type state;
		logic [DATA_W-1:0] pri;
		logic [DATA_W-1:0] sec;
		logic [RES_W-1:0] result;
		logic [RES_W-1:0] code;
		logic [3:0] bit_idx;
		logic [3:0] samp_cnt;
		logic sample;
		logic cmp_meta;
		logic cmp_sync;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} adcc_regs_type;
	localparam adcc_regs_type REGS_RESET = '{state: ST_IDLE, pri: PRI_RESET,
		sec: SEC_RESET, default: '0};
endpackage

// file: inc/adcc_tick_if.sv
// Link between the control module and its conversion clock generator
`timescale 1ns/1ps
interface adcc_tick_if;
	logic [1:0] clk_sel; // Clock select field
	logic range_sel; // Divider range bit
	logic run; // Conversion under way
	logic sleep; // Device asleep
	logic tick; // One-cycle conversion clock enable
	modport ctrl(output clk_sel, output range_sel, output run, output sleep, input tick);
	modport gen(input clk_sel, input range_sel, input run, input sleep, output tick);
endinterface

// file: src/adcc_tick_gen.sv
// Conversion clock enable: system clock divider or synchronised RC clock
`timescale 1ns/1ps
module adcc_tick_gen
	import adcc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rc_clk_i,
	adcc_tick_if.gen tk
);
	// Whole state of the generator
	typedef struct packed {
		logic rc_meta; // First synchroniser stage
		logic rc_sync; // Second synchroniser stage
		logic rc_prev; // Edge detect history
		logic [5:0] cnt; // Divider count
		logic tick;
	} adcc_gen_type;
	adcc_gen_type r;
	adcc_gen_type n;

	// Terminal count for a clock code and range
	function automatic logic [5:0] div_last(input logic [1:0] sel, input logic range);
		logic [5:0] v;
		v = DIV_LAST_2;
		unique case (sel)
			CLK_SEL_DIV_A: v = range ? DIV_LAST_4 : DIV_LAST_2;
			CLK_SEL_DIV_B: v = range ? DIV_LAST_16 : DIV_LAST_8;
			CLK_SEL_DIV_C: v = range ? DIV_LAST_64 : DIV_LAST_32;
			CLK_SEL_RC: v = DIV_LAST_2;
		endcase
		return v;
	endfunction

	assign tk.tick = r.tick;

	// Next state: divider or RC edge picks the tick
	always_comb begin
		logic rc_mode;
		rc_mode = (tk.clk_sel == CLK_SEL_RC);
		n = r;
		n.rc_meta = rc_clk_i;
		n.rc_sync = r.rc_meta;
		n.rc_prev = r.rc_sync;
		n.tick = 1'b0;
		if (!tk.run) begin
			n.cnt = '0;
		end else if (rc_mode) begin
			// RC clock keeps running in sleep
			n.tick = r.rc_sync && !r.rc_prev;
		end else if (!tk.sleep) begin
			// System divider, stalled while asleep
			if (r.cnt >= div_last(tk.clk_sel, tk.range_sel)) begin
				n.cnt = '0;
				n.tick = 1'b1;
			end else begin
				n.cnt = r.cnt + 6'h01;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// No divided tick while the device sleeps
	chk_sleep_no_div: assert property (@(posedge clk_i) disable iff (rst_i)
		(tk.sleep && tk.clk_sel != CLK_SEL_RC) |=> !tk.tick)
		else $error("divided tick during sleep");
endmodule

// file: sim/adcc_analog_model.sv
// Behavioural analog front end facing the converter control block
`timescale 1ns/1ps
module adcc_analog_model (
	input wire logic clk_i,
	input wire logic [adcc_pkg::RES_W*adcc_pkg::NUM_CH-1:0] levels_i,
	input wire logic [2:0] channel_sel_i,
	input wire logic sample_i,
	input wire logic power_i,
	input wire logic [adcc_pkg::RES_W-1:0] code_i,
	output logic comparator_o
);
	import adcc_pkg::*;
	logic [RES_W-1:0] held = '0; // Level frozen by the switch
	logic churn = 1'b0; // Noise while unpowered
	// Track the routed input while the switch is closed
	always @(posedge clk_i) begin
		churn <= ~churn;
		if (sample_i && channel_sel_i < 3'(NUM_CH)) begin
			held <= levels_i[channel_sel_i*RES_W +: RES_W];
		end
	end
	// Held level against trial code
	assign comparator_o = power_i ? (held >= code_i) : churn;
endmodule

// file: sim/adcc_conv_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_conv_ctrl_tb;
	import adcc_pkg::*;
	logic clk_i = 1'b0; // System clock
	logic rst_i = 1'b1; // Synchronous reset
	logic rc_clk = 1'b0; // Unrelated RC oscillator
	logic [ADDR_W-1:0] addr = '0; // Bus address
	logic [DATA_W-1:0] wdata = '0; // Bus write data
	logic wr = 1'b0; // Write strobe
	logic rd = 1'b0; // Read strobe
	logic trig = 1'b0; // Compare trigger
	logic sleep = 1'b0; // Device asleep
	logic [DATA_W-1:0] rdata;
	logic comp;
	logic [2:0] ch_sel;
	logic [NUM_CH-1:0] an_en;
	logic ref_hi;
	logic ref_lo;
	logic pwr;
	logic samp;
	logic [RES_W-1:0] code;
	logic irq;
	// Channel levels, four down to zero; edges of the range included
	logic [RES_W*NUM_CH-1:0] levels = {10'h201, 10'h155, 10'h2AA, 10'h3FF, 10'h000};
	int bad_count = 0;
	int checks_done = 0;
	// Clocks
	always #20 clk_i = ~clk_i;
	always #87 rc_clk = ~rc_clk;
	adcc_conv_ctrl #(.SAMPLE_TICKS(4'h2)) adcc_conv_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.special_trigger_i(trig), .sleep_i(sleep), .rc_clk_i(rc_clk), .comparator_i(comp),
		.channel_sel_o(ch_sel), .analog_enable_o(an_en), .ref_high_pin_o(ref_hi),
		.ref_low_pin_o(ref_lo), .converter_on_o(pwr), .sample_o(samp), .dac_code_o(code),
		.irq_o(irq));
	adcc_analog_model adcc_analog_model_inst (.clk_i(clk_i), .levels_i(levels),
		.channel_sel_i(ch_sel), .sample_i(samp), .power_i(pwr), .code_i(code),
		.comparator_o(comp));
	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask
	// One-cycle write
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	// One-cycle read, data taken in the following cycle
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(negedge clk_i);
		check(rdata, want);
	endtask
	// Bounded wait for the interrupt line
	task automatic wait_irq(inout int n);
		while (irq !== 1'b1 && n < 3000) begin
			@(negedge clk_i);
			n++;
		end
		check(irq, 1'b1);
	endtask
	// Result bytes, status flag and its clearing
	task automatic finish_conv(input int ch);
		rd_chk(ADDR_RES_HIGH, levels[ch*RES_W+2 +: 8]);
		rd_chk(ADDR_RES_LOW, {levels[ch*RES_W +: 2], 6'h00});
		rd_chk(ADDR_IRQ_STAT, 8'h01);
		wr_reg(ADDR_IRQ_STAT, 8'h03);
		repeat (2) @(negedge clk_i);
		check(irq, 1'b0);
	endtask
	// Register reset values and refused bits
	task automatic test_regs();
		check({pwr, samp, irq, ref_hi, ref_lo}, 5'h00);
		rd_chk(ADDR_CTRL_PRI, PRI_RESET);
		rd_chk(ADDR_CTRL_SEC, SEC_RESET);
		rd_chk(ADDR_IRQ_MASK, 8'h00);
		wr_reg(ADDR_CTRL_PRI, 8'hFA);
		rd_chk(ADDR_CTRL_PRI, 8'hF8);
		check(ch_sel, 3'h7);
		wr_reg(ADDR_CTRL_PRI, 8'h04);
		rd_chk(ADDR_CTRL_PRI, 8'h00);
		check({pwr, samp}, 2'h0);
		wr_reg(ADDR_CTRL_SEC, 8'hA5);
		rd_chk(ADDR_CTRL_SEC, 8'hA5);
		check({ref_lo, ref_hi, an_en}, 7'h65);
		wr_reg(8'h55, 8'hFF);
		rd_chk(8'h55, 8'h00);
		rd_chk(ADDR_CTRL_PRI, 8'h00);
		$display("registers test ended");
	endtask
	// Every clock code in both ranges, channels in turn
	task automatic test_conv(input int ch, input logic [1:0] cs, input logic rng);
		int n;
		int div;
		logic [DATA_W-1:0] pv;
		pv = {cs, ch[2:0], 3'b101};
		div = (rng ? 4 : 2) << (2 * cs);
		wr_reg(ADDR_CTRL_SEC, {1'b0, rng, 6'h1F});
		wr_reg(ADDR_CTRL_PRI, pv);
		rd_chk(ADDR_CTRL_PRI, pv);
		n = 2;
		wait_irq(n);
		// Ticks closer than the comparator sync lag stretch to four cycles
		if (cs != CLK_SEL_RC) begin
			check(n >= 11 * div && n <= 13 * ((div < 4) ? 4 : div) + 10, 1'b1);
		end
		check(ch_sel, ch[2:0]);
		rd_chk(ADDR_CTRL_PRI, pv & 8'hFB);
		finish_conv(ch);
		$display("conversion test ended, channel %0d code %0d range %0d", ch, cs, rng);
	endtask
	// Compare trigger, masked done flag, unpowered trigger
	task automatic test_trigger();
		int n;
		wr_reg(ADDR_CTRL_SEC, 8'h00);
		wr_reg(ADDR_CTRL_PRI, 8'h09);
		wr_reg(ADDR_IRQ_MASK, 8'h02);
		@(posedge clk_i);
		trig <= 1'b1;
		@(posedge clk_i);
		trig <= 1'b0;
		repeat (3) @(negedge clk_i);
		check(irq, 1'b1);
		rd_chk(ADDR_CTRL_PRI, 8'h0D);
		wr_reg(ADDR_IRQ_STAT, 8'h02);
		repeat (60) @(negedge clk_i);
		check(irq, 1'b0);
		rd_chk(ADDR_CTRL_PRI, 8'h09);
		rd_chk(ADDR_IRQ_STAT, 8'h01);
		rd_chk(ADDR_RES_HIGH, levels[RES_W+2 +: 8]);
		wr_reg(ADDR_IRQ_STAT, 8'h01);
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		wr_reg(ADDR_CTRL_PRI, 8'h00);
		@(posedge clk_i);
		trig <= 1'b1;
		@(posedge clk_i);
		trig <= 1'b0;
		rd_chk(ADDR_CTRL_PRI, 8'h00);
		check(samp, 1'b0);
		$display("trigger test ended");
	endtask
	// Divided clock stalls asleep; RC clock keeps going
	task automatic test_sleep();
		int n;
		@(posedge clk_i);
		sleep <= 1'b1;
		wr_reg(ADDR_CTRL_PRI, 8'h05);
		repeat (200) @(negedge clk_i);
		check(irq, 1'b0);
		rd_chk(ADDR_CTRL_PRI, 8'h05);
		@(posedge clk_i);
		sleep <= 1'b0;
		n = 0;
		wait_irq(n);
		finish_conv(0);
		@(posedge clk_i);
		sleep <= 1'b1;
		test_conv(3, CLK_SEL_RC, 1'b0);
		@(posedge clk_i);
		sleep <= 1'b0;
		$display("sleep test ended");
	endtask
	// Verdict
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Watchdog, far beyond the longest expected run
	initial begin
		#(40 * 40000);
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		test_regs();
		wr_reg(ADDR_IRQ_MASK, 8'h01);
		for (int i = 0; i < 8; i++) begin
			test_conv(i % NUM_CH, i[1:0], i[2]);
		end
		test_trigger();
		test_sleep();
		conclude();
	end
endmodule
